// ---- hw/sarrd_pkg.sv ----
`default_nettype none
package sarrd_pkg;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned FIFO_DEPTH   = 2;
  localparam int unsigned SYS_CLK_MHZ  = 25;
  localparam int unsigned CONV_TIME_NS = 400;
  localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CNT_W   = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
  localparam int unsigned POS_W        = 5;
  localparam logic [POS_W-1:0] POS_LOAD      = 5'h01;
  localparam logic [POS_W-1:0] POS_FIRST_BIT = 5'h02;
  localparam logic [POS_W-1:0] POS_LAST_BIT  = 5'h11;
  localparam logic [POS_W-1:0] SYNC_HI_WORD  = 5'h08;
  localparam logic [POS_W-1:0] SYNC_HI_BYTE  = 5'h04;
  localparam logic [POS_W-1:0] FRAME_BYTE    = 5'h08;
  localparam logic [POS_W-1:0] POS_ONE       = 5'h01;
  localparam logic [POS_W-1:0] POS_ZERO      = 5'h00;
  localparam logic [1:0]       CNT_FULL      = 2'h2;
  localparam logic [1:0]       CNT_ONE       = 2'h1;
  localparam logic [1:0]       CNT_ZERO      = 2'h0;

  typedef enum logic [2:0] {
    SARRD_WAIT,
    SARRD_SAMPLE,
    SARRD_CONVERT,
    SARRD_NAP,
    SARRD_PDOWN
  } sarrd_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              valid;
  } sarrd_word_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic strobe;
    logic power_down_n;
    logic nap;
    logic cascade;
    logic byte_mode;
    logic latency;
    logic clk_out_en;
    logic drive_double;
  } sarrd_pins_t;
endpackage
`default_nettype wire

// ---- hw/sarrd_top.sv ----
`default_nettype none

module sarrd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end
endmodule // sarrd_sync

module sarrd_top (
  input  wire logic                        clk_sys_i,
  input  wire logic                        srst_i,
  input  wire logic                        int_serial_clk_i,
  input  wire logic                        ext_serial_clk_i,
  input  wire logic                        clk_src_internal_i,
  input  wire logic                        chip_select_n_i,
  input  wire logic                        read_n_i,
  input  wire logic                        cmos_convert_strobe_n_i,
  input  wire logic                        diff_convert_strobe_n_i,
  input  wire logic                        power_down_n_i,
  input  wire logic                        nap_i,
  input  wire logic                        topology_cascade_i,
  input  wire logic                        byte_mode_i,
  input  wire logic                        read_latency_select_i,
  input  wire logic                        cascade_clock_out_enable_i,
  input  wire logic                        drive_double_select_i,
  input  wire logic [sarrd_pkg::WORD_W-1:0] conv_result_i,
  input  wire logic                        upstream_serial_in_i,
  input  wire logic                        upstream_sync_in_i,
  output logic                             busy_o,
  output logic                             bus_owned_o,
  output logic                             nap_state_o,
  output logic                             powered_down_o,
  output logic                             read_refused_o,
  output logic                             serial_clk_o,
  output logic                             serial_clk_oe_o,
  output logic                             serial_data_out_o,
  output logic                             serial_data_oe_o,
  output logic                             frame_sync_o,
  output logic                             frame_sync_oe_o,
  output logic                             drive_double_o
);
  // clock source is a static strap; switching it live can glitch the link clock
  logic link_clk;
  assign link_clk     = clk_src_internal_i ? int_serial_clk_i : ext_serial_clk_i;
  assign serial_clk_o = link_clk;

  sarrd_pkg::sarrd_pins_t pins_raw;
  sarrd_pkg::sarrd_pins_t pins;

  assign pins_raw.cs_n         = chip_select_n_i;
  assign pins_raw.rd_n         = read_n_i;
  assign pins_raw.strobe       = cmos_convert_strobe_n_i | diff_convert_strobe_n_i;
  assign pins_raw.power_down_n = power_down_n_i;
  assign pins_raw.nap          = nap_i;
  assign pins_raw.cascade      = topology_cascade_i;
  assign pins_raw.byte_mode    = byte_mode_i;
  assign pins_raw.latency      = read_latency_select_i;
  assign pins_raw.clk_out_en   = cascade_clock_out_enable_i;
  assign pins_raw.drive_double = drive_double_select_i;

  sarrd_sync #(.W($bits(sarrd_pkg::sarrd_pins_t))) u_sys_sync (
    .clk_i (clk_sys_i),
    .d_i   (pins_raw),
    .q_o   (pins)
  );

  // edge detection on the synchronised pins
  logic strobe_d_reg;
  logic rd_n_d_reg;
  logic strobe_rise;
  logic strobe_fall;
  logic rd_fall;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      strobe_d_reg <= 1'b0;
      rd_n_d_reg   <= 1'b1;
    end else begin
      strobe_d_reg <= pins.strobe;
      rd_n_d_reg   <= pins.rd_n;
    end
  end

  assign strobe_rise = pins.strobe & ~strobe_d_reg;
  assign strobe_fall = ~pins.strobe & strobe_d_reg;
  assign rd_fall     = ~pins.rd_n & rd_n_d_reg;

  // conversion sequencer
  sarrd_pkg::sarrd_state_t state_reg;
  logic [sarrd_pkg::CONV_CNT_W-1:0] conv_cnt_reg;
  logic                             resample_reg;
  sarrd_pkg::sarrd_word_t           last_word_reg;
  sarrd_pkg::sarrd_word_t           prev_word_reg;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg     <= sarrd_pkg::SARRD_WAIT;
      conv_cnt_reg  <= '0;
      resample_reg  <= 1'b0;
      last_word_reg <= '0;
      prev_word_reg <= '0;
    end else if (!pins.power_down_n) begin
      state_reg    <= sarrd_pkg::SARRD_PDOWN;
      resample_reg <= 1'b0;
    end else begin
      case (state_reg)
        sarrd_pkg::SARRD_PDOWN: begin
          state_reg <= sarrd_pkg::SARRD_WAIT;
        end
        sarrd_pkg::SARRD_WAIT, sarrd_pkg::SARRD_NAP: begin
          if (strobe_rise) begin
            state_reg <= sarrd_pkg::SARRD_SAMPLE;
          end
        end
        sarrd_pkg::SARRD_SAMPLE: begin
          if (strobe_fall) begin
            state_reg    <= sarrd_pkg::SARRD_CONVERT;
            conv_cnt_reg <= '0;
          end
        end
        sarrd_pkg::SARRD_CONVERT: begin
          if (strobe_fall) begin
            // aborted result stays marked invalid until a full cycle completes
            state_reg           <= sarrd_pkg::SARRD_WAIT;
            resample_reg        <= 1'b0;
            prev_word_reg       <= last_word_reg;
            last_word_reg.valid <= 1'b0;
          end else if (conv_cnt_reg == sarrd_pkg::CONV_LAST) begin
            prev_word_reg       <= last_word_reg;
            last_word_reg.data  <= conv_result_i;
            last_word_reg.valid <= 1'b1;
            resample_reg        <= 1'b0;
            if (resample_reg || strobe_rise) begin
              state_reg <= sarrd_pkg::SARRD_SAMPLE;
            end else if (pins.nap) begin
              state_reg <= sarrd_pkg::SARRD_NAP;
            end else begin
              state_reg <= sarrd_pkg::SARRD_WAIT;
            end
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
            if (strobe_rise) begin
              resample_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= sarrd_pkg::SARRD_WAIT;
        end
      endcase
    end
  end

  // read request and two-entry buffer ahead of the link crossing
  sarrd_pkg::sarrd_word_t mem [sarrd_pkg::FIFO_DEPTH];
  sarrd_pkg::sarrd_word_t xfer_word_reg;
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       fifo_ready;
  logic       fifo_valid;
  logic       read_req;
  logic       push;
  logic       pop;
  logic       req_tgl_reg;
  logic       ack_tgl_sync;
  logic       outstanding;

  assign read_req = rd_fall && !pins.cs_n &&
                    (state_reg == sarrd_pkg::SARRD_WAIT ||
                     state_reg == sarrd_pkg::SARRD_SAMPLE);
  assign fifo_ready  = (count_reg != sarrd_pkg::CNT_FULL);
  assign fifo_valid  = (count_reg != sarrd_pkg::CNT_ZERO);
  assign push        = read_req && fifo_ready;
  assign outstanding = (req_tgl_reg != ack_tgl_sync);
  // drain stalls while the link still shifts the previous word
  assign pop         = fifo_valid && !outstanding;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= pins.latency ? prev_word_reg : last_word_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_ptr_reg    <= 1'b0;
      rd_ptr_reg    <= 1'b0;
      count_reg     <= sarrd_pkg::CNT_ZERO;
      req_tgl_reg   <= 1'b0;
      xfer_word_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg    <= ~rd_ptr_reg;
        xfer_word_reg <= mem[rd_ptr_reg];
        req_tgl_reg   <= ~req_tgl_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + sarrd_pkg::CNT_ONE;
      end else if (pop && !push) begin
        count_reg <= count_reg - sarrd_pkg::CNT_ONE;
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_o          <= 1'b0;
      bus_owned_o     <= 1'b0;
      nap_state_o     <= 1'b0;
      powered_down_o  <= 1'b0;
      read_refused_o  <= 1'b0;
      serial_clk_oe_o <= 1'b0;
      drive_double_o  <= 1'b0;
    end else begin
      busy_o         <= (state_reg == sarrd_pkg::SARRD_CONVERT);
      nap_state_o    <= (state_reg == sarrd_pkg::SARRD_NAP);
      powered_down_o <= (state_reg == sarrd_pkg::SARRD_PDOWN);
      read_refused_o <= read_req && !fifo_ready;
      if (push) begin
        bus_owned_o <= 1'b1;
      end else if (!fifo_valid && !outstanding) begin
        bus_owned_o <= 1'b0;
      end
      serial_clk_oe_o <= pins.cascade ? pins.clk_out_en : 1'b1;
      drive_double_o  <= pins.cascade & pins.drive_double;
    end
  end

  // link domain
  logic link_rst_meta_reg;
  logic link_rst_reg;

  always_ff @(posedge link_clk) begin
    link_rst_meta_reg <= srst_i;
    link_rst_reg      <= link_rst_meta_reg;
  end

  logic [4:0] link_raw;
  logic [4:0] link_s;
  logic       l_req_tgl;
  logic       l_cs_high;
  logic       l_cascade;
  logic       l_byte;
  logic       l_pwr_off;
  logic [1:0] up_s;
  logic       ack_tgl_reg;

  assign link_raw = {req_tgl_reg, pins.cs_n, pins.cascade, pins.byte_mode,
                     (state_reg == sarrd_pkg::SARRD_PDOWN)};
  assign {l_req_tgl, l_cs_high, l_cascade, l_byte, l_pwr_off} = link_s;

  sarrd_sync #(.W(5)) u_link_sync (
    .clk_i (link_clk),
    .d_i   (link_raw),
    .q_o   (link_s)
  );

  sarrd_sync #(.W(2)) u_up_sync (
    .clk_i (link_clk),
    .d_i   ({upstream_sync_in_i, upstream_serial_in_i}),
    .q_o   (up_s)
  );

  sarrd_sync #(.W(1)) u_ack_sync (
    .clk_i (clk_sys_i),
    .d_i   (ack_tgl_reg),
    .q_o   (ack_tgl_sync)
  );

  logic                         active_reg;
  logic                         relay_reg;
  logic [sarrd_pkg::POS_W-1:0]  pos_reg;
  logic [sarrd_pkg::WORD_W-1:0] shift_reg;
  logic                         sync_hi;

  // sync high for the first half of each frame
  assign sync_hi = l_byte ?
      (pos_reg < sarrd_pkg::SYNC_HI_BYTE ||
       (pos_reg >= sarrd_pkg::FRAME_BYTE &&
        pos_reg < sarrd_pkg::FRAME_BYTE + sarrd_pkg::SYNC_HI_BYTE)) :
      (pos_reg < sarrd_pkg::SYNC_HI_WORD);

  always_ff @(posedge link_clk) begin
    if (link_rst_reg) begin
      ack_tgl_reg       <= 1'b0;
      active_reg        <= 1'b0;
      relay_reg         <= 1'b0;
      pos_reg           <= sarrd_pkg::POS_ZERO;
      shift_reg         <= '0;
      serial_data_out_o <= 1'b0;
      frame_sync_o      <= 1'b0;
    end else if (!active_reg) begin
      if (l_req_tgl != ack_tgl_reg) begin
        active_reg   <= 1'b1;
        relay_reg    <= 1'b1;
        pos_reg      <= sarrd_pkg::POS_ONE;
        frame_sync_o <= 1'b1;
      end else begin
        // daisy chain: pass the upstream frame through after our own
        frame_sync_o      <= l_cascade ? 1'b0 : up_s[1];
        serial_data_out_o <= l_cascade ? 1'b0 : up_s[0];
        if (l_cs_high) begin
          relay_reg <= 1'b0;
        end
      end
    end else begin
      pos_reg      <= pos_reg + sarrd_pkg::POS_ONE;
      frame_sync_o <= sync_hi;
      if (pos_reg == sarrd_pkg::POS_LOAD) begin
        shift_reg <= xfer_word_reg.data;
      end else if (pos_reg >= sarrd_pkg::POS_FIRST_BIT) begin
        serial_data_out_o <= shift_reg[sarrd_pkg::WORD_W-1];
        shift_reg         <= shift_reg << 1;
      end
      if (pos_reg == sarrd_pkg::POS_LAST_BIT) begin
        active_reg  <= 1'b0;
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_reg) begin
      serial_data_oe_o <= 1'b0;
      frame_sync_oe_o  <= 1'b0;
    end else begin
      serial_data_oe_o <= !l_cs_high && !l_pwr_off &&
                          (active_reg || (!l_cascade && relay_reg));
      frame_sync_oe_o  <= !l_cs_high && !l_pwr_off &&
                          (active_reg || (!l_cascade && relay_reg));
    end
  end
endmodule // sarrd_top
`default_nettype wire

// ---- testbench/sarrd_chk.sv ----
`default_nettype none
module sarrd_chk (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic int_serial_clk_i,
  input wire logic ext_serial_clk_i,
  input wire logic clk_src_internal_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic cmos_convert_strobe_n_i,
  input wire logic diff_convert_strobe_n_i,
  input wire logic power_down_n_i,
  input wire logic nap_i,
  input wire logic topology_cascade_i,
  input wire logic cascade_clock_out_enable_i,
  input wire logic busy_o,
  input wire logic bus_owned_o,
  input wire logic nap_state_o,
  input wire logic powered_down_o,
  input wire logic read_refused_o,
  input wire logic serial_clk_o,
  input wire logic serial_clk_oe_o,
  input wire logic serial_data_oe_o,
  input wire logic frame_sync_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic       strobe;
  logic [3:0] cs_hi_cnt;
  assign strobe = cmos_convert_strobe_n_i | diff_convert_strobe_n_i;
  // select is high long enough to cross both synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !chip_select_n_i) cs_hi_cnt <= 4'h0;
    else if (cs_hi_cnt != 4'hf) cs_hi_cnt <= cs_hi_cnt + 4'h1;
  end
  sequence s_sample;
    !busy_o && power_down_n_i && !strobe ##1 strobe [*4];
  endsequence
  sequence s_read_req;
    $fell(read_n_i) && !chip_select_n_i && !busy_o && !strobe && !nap_state_o
      && !powered_down_o && power_down_n_i && !bus_owned_o;
  endsequence
  chk_conv_start: assert property (s_sample ##1 !strobe |-> ##[2:6] busy_o)
    else $error("no conversion after strobe fall");
  chk_busy_bound: assert property ($rose(busy_o) |-> ##[1:12] !busy_o)
    else $error("busy outlived conversion time");
  chk_pd_enter: assert property (!power_down_n_i [*6] |-> powered_down_o)
    else $error("no power down");
  chk_pd_leave: assert property (power_down_n_i [*7] |-> !powered_down_o)
    else $error("stuck in power down");
  chk_nap_enter: assert property ($fell(busy_o) && nap_i |-> ##[0:2] nap_state_o)
    else $error("nap not entered");
  chk_clk_select: assert property (
      serial_clk_o == (clk_src_internal_i ? int_serial_clk_i : ext_serial_clk_i))
    else $error("wrong serial clock source");
  // pins need three edges to reach the registered enable
  chk_clk_oe: assert property (
      (!$past(srst_i) && $stable(topology_cascade_i)
      && $stable(cascade_clock_out_enable_i)) [*3] |->
      serial_clk_oe_o == (!topology_cascade_i || cascade_clock_out_enable_i))
    else $error("serial clock enable wrong");
  chk_cs_release: assert property (
      cs_hi_cnt >= 4'hc |-> !serial_data_oe_o && !frame_sync_oe_o)
    else $error("outputs driven with select high");
  chk_read_owned: assert property (s_read_req |-> ##[2:6] bus_owned_o)
    else $error("read not taken");
  chk_refuse_pulse: assert property (read_refused_o |-> bus_owned_o ##1 !read_refused_o)
    else $error("refusal pulse wrong");
endmodule // sarrd_chk
bind sarrd_top sarrd_chk sarrd_chk_inst (.*);
`default_nettype wire

// ---- testbench/sarrd_rx_model.sv ----
`default_nettype none
module sarrd_rx_model (
  input wire logic serial_clk_i,
  input wire logic sync_i,
  input wire logic data_i,
  input wire logic data_oe_i,
  input wire logic byte_mode_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words[$];
  int          cd[$];
  int          period = 0;
  int          since = 0;
  logic [15:0] stream = 16'h0000;
  logic        sync_d = 1'b0;
  logic        half = 1'b0;
  // released line reads as the inverse, so a late enable corrupts the word
  always @(negedge serial_clk_i) begin
    stream = {stream[14:0], data_oe_i ? data_i : ~data_i};
    since = since + 1;
    if (sync_i && !sync_d) begin
      period = since;
      since = 0;
      // d0 leaves on the 17th rising edge after the sync rise
      if (!(byte_mode_i && half)) cd.push_back(18);
      half = byte_mode_i && !half;
    end
    sync_d = sync_i;
    foreach (cd[i]) cd[i] = cd[i] - 1;
    if (cd.size() > 0 && cd[0] == 0) begin
      words.push_back(stream);
      void'(cd.pop_front());
    end
  end
endmodule // sarrd_rx_model
`default_nettype wire

// ---- testbench/sarrd_top_bench.sv ----
`default_nettype none
module sarrd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, chip_select_n_i = 1'b0, read_n_i = 1'b1;
  logic int_serial_clk_i = 1'b0, ext_serial_clk_i = 1'b0, clk_src_internal_i = 1'b1;
  logic cmos_convert_strobe_n_i = 1'b0, diff_convert_strobe_n_i = 1'b0;
  logic power_down_n_i = 1'b1, nap_i = 1'b0, topology_cascade_i = 1'b0;
  logic byte_mode_i = 1'b0, read_latency_select_i = 1'b0;
  logic cascade_clock_out_enable_i = 1'b0, drive_double_select_i = 1'b0;
  logic upstream_serial_in_i = 1'b0, upstream_sync_in_i = 1'b0;
  logic [sarrd_pkg::WORD_W-1:0] conv_result_i = 16'h0000;
  logic busy_o, bus_owned_o, nap_state_o, powered_down_o, read_refused_o, drive_double_o;
  logic serial_clk_o, serial_clk_oe_o, serial_data_out_o, serial_data_oe_o;
  logic frame_sync_o, frame_sync_oe_o;
  int   n_errors = 0;
  int   n_compared = 0;
  int   cyc = 0;
  int   refused = 0;
  int   n;
  sarrd_top sarrd_top_inst (.*);
  sarrd_rx_model sarrd_rx_model_inst (
    .serial_clk_i (serial_clk_o),
    .sync_i       (frame_sync_o),
    .data_i       (serial_data_out_o),
    .data_oe_i    (serial_data_oe_o),
    .byte_mode_i  (byte_mode_i)
  );
  initial forever #20 clk_sys_i = ~clk_sys_i;
  // both serial sources free-running, as their oscillators would be
  initial begin
    #7;
    forever #24 int_serial_clk_i = ~int_serial_clk_i;
  end
  initial begin
    #13;
    forever #24 ext_serial_clk_i = ~ext_serial_clk_i;
  end
  task automatic results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk_sys_i) begin
    cyc = cyc + 1;
    if (read_refused_o === 1'b1) refused = refused + 1;
    if (cyc == 8000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic do_reset;
    srst_i = 1'b1;
    tick(3);
    srst_i = 1'b0;
    tick(4);
  endtask
  task automatic conv(input bit dif, input logic [15:0] res, input int ab, output int len);
    conv_result_i = res;
    if (dif) diff_convert_strobe_n_i = 1'b1;
    else cmos_convert_strobe_n_i = 1'b1;
    tick(4);
    cmos_convert_strobe_n_i = 1'b0;
    diff_convert_strobe_n_i = 1'b0;
    len = 0;
    for (int i = 0; i < 10 && busy_o !== 1'b1; i++) tick(1);
    if (ab > 0) begin
      tick(ab);
      cmos_convert_strobe_n_i = 1'b1;
      tick(2);
      cmos_convert_strobe_n_i = 1'b0;
    end
    while (busy_o === 1'b1 && len < 20) begin
      tick(1);
      len++;
    end
  endtask
  task automatic rd;
    read_n_i = 1'b0;
    tick(3);
    read_n_i = 1'b1;
    tick(3);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400 && bus_owned_o !== 1'b0; i++) tick(1);
    tick(8);
  endtask
  task automatic t_read;
    sarrd_rx_model_inst.words.delete();
    refused = 0;
    conv(1'b0, 16'ha5c3, 0, n);
    chk(16'(n), 16'(sarrd_pkg::CONV_CYCLES));
    repeat (4) rd();
    wait_idle();
    chk(16'(sarrd_rx_model_inst.words.size()), 16'h0003);
    chk(16'(refused), 16'h0001);
    foreach (sarrd_rx_model_inst.words[i]) chk(sarrd_rx_model_inst.words[i], 16'ha5c3);
    // after its own frame the daisy link relays the upstream pins
    upstream_sync_in_i = 1'b1;
    upstream_serial_in_i = 1'b1;
    tick(6);
    chk(frame_sync_o, 1'b1);
    chk(serial_data_out_o, 1'b1);
    chk(serial_data_oe_o, 1'b1);
    upstream_sync_in_i = 1'b0;
    upstream_serial_in_i = 1'b0;
    // let the model drop the relayed frame before the next scenario
    tick(24);
  endtask
  task automatic t_latency_byte;
    byte_mode_i = 1'b1;
    read_latency_select_i = 1'b1;
    sarrd_rx_model_inst.words.delete();
    conv(1'b1, 16'h3c96, 0, n);
    rd();
    wait_idle();
    chk(16'(sarrd_rx_model_inst.words.size()), 16'h0001);
    chk(sarrd_rx_model_inst.words[0], 16'ha5c3);
    chk(16'(sarrd_rx_model_inst.period), 16'h0008);
    byte_mode_i = 1'b0;
    read_latency_select_i = 1'b0;
  endtask
  task automatic t_cs_high;
    chip_select_n_i = 1'b1;
    tick(14);
    chk(serial_data_oe_o, 1'b0);
    chk(frame_sync_oe_o, 1'b0);
    rd();
    chk(bus_owned_o, 1'b0);
    chip_select_n_i = 1'b0;
    tick(4);
  endtask
  task automatic t_abort_nap;
    conv(1'b0, 16'h1234, 1, n);
    chk(n < 6, 1'b1);
    tick(4);
    nap_i = 1'b1;
    conv(1'b0, 16'h0f0f, 0, n);
    tick(1);
    chk(nap_state_o, 1'b1);
    cmos_convert_strobe_n_i = 1'b1;
    nap_i = 1'b0;
    tick(6);
    chk(nap_state_o, 1'b0);
    cmos_convert_strobe_n_i = 1'b0;
    tick(16);
  endtask
  task automatic t_pdown;
    power_down_n_i = 1'b0;
    tick(8);
    chk(powered_down_o, 1'b1);
    power_down_n_i = 1'b1;
    tick(8);
    chk(powered_down_o, 1'b0);
  endtask
  task automatic t_cascade;
    topology_cascade_i = 1'b1;
    tick(3);
    chk(serial_clk_oe_o, 1'b0);
    cascade_clock_out_enable_i = 1'b1;
    drive_double_select_i = 1'b1;
    tick(3);
    chk(serial_clk_oe_o, 1'b1);
    chk(drive_double_o, 1'b1);
    topology_cascade_i = 1'b0;
    cascade_clock_out_enable_i = 1'b0;
    tick(3);
    chk(serial_clk_oe_o, 1'b1);
    chk(drive_double_o, 1'b0);
    drive_double_select_i = 1'b0;
  endtask
  initial begin
    do_reset();
    t_read();
    t_latency_byte();
    t_abort_nap();
    t_pdown();
    t_cascade();
    clk_src_internal_i = 1'b0;
    do_reset();
    t_read();
    t_cs_high();
    results();
  end
endmodule // sarrd_top_bench
`default_nettype wire
